// >>> hdl/fbrs_seq.v
// burst read sequencer of the synchronous flash device
// Operation
// - 4-6 ws: extra cycles max(0, offset+ws-9)
// - 3 ws: one extra cycle only at offset 7
// - 2 ws: no boundary wait cycles ever
// - continuous burst increments, wraps to zero
// - chip select high or reset stops burst
// - address strobe low restarts burst at address
// - first line crossing adds latency unless suspended sector
// - busy bank: drive status, ignore clock
// - wrap burst reads 8, 16, 32 words
// - wrap burst delivers each word once, ends
// - group top wraps low bits, keeps upper
// - wrap mode inserts no boundary wait cycles
// - groups aligned to their own size
// - reset defaults to async, config enables burst
`default_nettype none
`include "fbrs_consts.vh"

module fbrs_seq (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // host pins
  input wire hw_reset_n_i,
  input wire chip_sel_n_i,
  input wire address_valid_strobe_n_i,
  input wire burst_clk_i,
  input wire [`FBRS_ADDR_W-1:0] addr_i,
  // configuration load
  input wire cfg_wr_i,
  input wire [1:0] cfg_mode_i,
  input wire [`FBRS_WS_W-1:0] cfg_wait_i,
  // array side
  input wire [`FBRS_DATA_W-1:0] array_data_i,
  input wire bank_busy_i,
  input wire sect_suspended_i,
  input wire [`FBRS_DATA_W-1:0] status_data_i,
  output wire [`FBRS_ADDR_W-1:0] array_addr_o,
  // data pins
  output wire [`FBRS_DATA_W-1:0] dq_o,
  output wire dq_oe_n_o,
  output wire rdy_o,
  output wire sync_mode_o
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_LAT = 3'h1;
  localparam ST_BURST = 3'h2;
  localparam ST_WAIT = 3'h3;
  localparam ST_STAT = 3'h4;
  localparam ST_DONE = 3'h5;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // boundary penalty from start offset and initial wait count
  function [`FBRS_WS_W-1:0] pen_calc;
    input [2:0] ofs;
    input [`FBRS_WS_W-1:0] ws;
    reg [4:0] sum;
    reg [4:0] dif;
    begin
      sum = {2'h0, ofs} + {1'h0, ws};
      // subtract at full width so long wait counts keep their top bit
      dif = sum - `FBRS_PEN_BASE;
      if (sum > `FBRS_PEN_BASE) begin
        pen_calc = dif[`FBRS_WS_W-1:0];
      end else begin
        pen_calc = 4'h0;
      end
    end
  endfunction

  function [`FBRS_CNT_W-1:0] grp_size;
    input [1:0] mode;
    begin
      case (mode)
        `FBRS_MODE_W8: grp_size = `FBRS_GRP8;
        `FBRS_MODE_W16: grp_size = `FBRS_GRP16;
        `FBRS_MODE_W32: grp_size = `FBRS_GRP32;
        default: grp_size = 6'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // bit 3 reset, 2 select, 1 strobe, 0 burst clock
  reg [3:0] pin_s1_r;
  reg [3:0] pin_s2_r;
  reg [`FBRS_ADDR_W-1:0] addr_s1_r;
  reg [`FBRS_ADDR_W-1:0] addr_s2_r;
  reg bclk_d_r;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      pin_s1_r <= 4'hE;
      pin_s2_r <= 4'hE;
      addr_s1_r <= `FBRS_RST_ADDR;
      addr_s2_r <= `FBRS_RST_ADDR;
      bclk_d_r <= 1'b0;
    end else begin
      pin_s1_r <= {hw_reset_n_i, chip_sel_n_i, address_valid_strobe_n_i, burst_clk_i};
      pin_s2_r <= pin_s1_r;
      addr_s1_r <= addr_i;
      addr_s2_r <= addr_s1_r;
      bclk_d_r <= pin_s2_r[0];
    end
  end

  wire hw_rst = ~pin_s2_r[3];
  wire sel = ~pin_s2_r[2];
  wire avd = ~pin_s2_r[1];
  wire bclk_rise = pin_s2_r[0] & ~bclk_d_r;
  wire int_rst = rst_i | hw_rst;

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  reg sync_en_r;
  reg [1:0] mode_r;
  reg [`FBRS_WS_W-1:0] ws_r;

  // reads stay asynchronous until the host loads a configuration
  always @(posedge mclk_i) begin
    if (int_rst) begin
      sync_en_r <= 1'b0;
      mode_r <= `FBRS_RST_MODE;
      ws_r <= `FBRS_RST_WS;
    end else if (cfg_wr_i) begin
      sync_en_r <= 1'b1;
      mode_r <= cfg_mode_i;
      ws_r <= cfg_wait_i;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg [`FBRS_ADDR_W-1:0] addr_r;
  reg [`FBRS_ADDR_W-1:0] addr_nxt;
  reg [1:0] bmode_r;
  reg [1:0] bmode_nxt;
  reg [`FBRS_WS_W-1:0] cnt_r;
  reg [`FBRS_WS_W-1:0] cnt_nxt;
  reg [`FBRS_WS_W-1:0] pen_r;
  reg [`FBRS_WS_W-1:0] pen_nxt;
  reg pen_used_r;
  reg pen_used_nxt;
  reg [`FBRS_CNT_W-1:0] words_r;
  reg [`FBRS_CNT_W-1:0] words_nxt;
  reg [`FBRS_DATA_W-1:0] dq_r;
  reg [`FBRS_DATA_W-1:0] dq_nxt;
  reg oe_n_r;
  reg oe_n_nxt;
  reg rdy_r;
  reg rdy_nxt;

  wire [`FBRS_ADDR_W-1:0] step_addr;
  wire line_cross;

  fbrs_addr_step u_step (
    .addr_i(addr_r),
    .mode_i(bmode_r),
    .next_o(step_addr),
    .line_cross_o(line_cross)
  );

  wire [`FBRS_CNT_W-1:0] words_inc = words_r + 6'h01;
  wire wrap_last = (bmode_r != `FBRS_MODE_CONT) && (words_inc == grp_size(bmode_r));

  // word delivery shared by the latency exit and the burst state
  reg do_dlv;

  always @* begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    bmode_nxt = bmode_r;
    cnt_nxt = cnt_r;
    pen_nxt = pen_r;
    pen_used_nxt = pen_used_r;
    words_nxt = words_r;
    dq_nxt = dq_r;
    oe_n_nxt = oe_n_r;
    rdy_nxt = rdy_r;
    do_dlv = 1'b0;
    if (!sel || !sync_en_r) begin
      // deselect ends any burst at once
      st_nxt = ST_IDLE;
      oe_n_nxt = 1'b1;
      rdy_nxt = 1'b0;
    end else if (bclk_rise && avd) begin
      // strobe low latches a fresh address, aborting whatever ran
      st_nxt = ST_LAT;
      addr_nxt = addr_s2_r;
      bmode_nxt = mode_r;
      cnt_nxt = ws_r;
      pen_nxt = (mode_r == `FBRS_MODE_CONT) ?
                pen_calc(addr_s2_r[`FBRS_OFS_MSB:`FBRS_OFS_LSB], ws_r) : 4'h0;
      pen_used_nxt = 1'b0;
      words_nxt = 6'h00;
      oe_n_nxt = 1'b1;
      rdy_nxt = 1'b0;
    end else if (bclk_rise) begin
      case (st_r)
        ST_LAT: begin
          if (cnt_r <= 4'h1) begin
            oe_n_nxt = 1'b0;
            do_dlv = 1'b1;
          end else begin
            cnt_nxt = cnt_r - 4'h1;
          end
        end
        ST_BURST: begin
          do_dlv = 1'b1;
        end
        ST_WAIT: begin
          // no address step while a wait cycle is inserted
          rdy_nxt = 1'b0;
          if (cnt_r <= 4'h1) begin
            st_nxt = ST_BURST;
          end else begin
            cnt_nxt = cnt_r - 4'h1;
          end
        end
        ST_STAT: begin
          dq_nxt = status_data_i;
        end
        ST_DONE: begin
          oe_n_nxt = 1'b1;
          rdy_nxt = 1'b0;
          st_nxt = ST_IDLE;
        end
        default: begin
          st_nxt = ST_IDLE;
        end
      endcase
    end else if (st_r == ST_STAT) begin
      // status tracks the array even without clock edges
      dq_nxt = status_data_i;
    end
    // kept inline so every input it reads wakes this process
    if (do_dlv) begin
      if (bank_busy_i) begin
        // busy bank answers with status and stops listening to the clock
        st_nxt = ST_STAT;
        dq_nxt = status_data_i;
        rdy_nxt = 1'b1;
      end else begin
        dq_nxt = array_data_i;
        rdy_nxt = 1'b1;
        addr_nxt = step_addr;
        words_nxt = words_inc;
        if (wrap_last) begin
          st_nxt = ST_DONE;
        end else if (line_cross && !sect_suspended_i && !pen_used_r && pen_r != 4'h0) begin
          // only the first line crossing of a burst pays the penalty
          st_nxt = ST_WAIT;
          cnt_nxt = pen_r;
          pen_used_nxt = 1'b1;
        end else begin
          st_nxt = ST_BURST;
          if (line_cross) begin
            pen_used_nxt = 1'b1;
          end
        end
      end
    end
  end

  always @(posedge mclk_i) begin
    if (int_rst) begin
      st_r <= ST_IDLE;
      addr_r <= `FBRS_RST_ADDR;
      bmode_r <= `FBRS_RST_MODE;
      cnt_r <= 4'h0;
      pen_r <= 4'h0;
      pen_used_r <= 1'b0;
      words_r <= 6'h00;
      dq_r <= `FBRS_RST_DQ;
      oe_n_r <= 1'b1;
      rdy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      bmode_r <= bmode_nxt;
      cnt_r <= cnt_nxt;
      pen_r <= pen_nxt;
      pen_used_r <= pen_used_nxt;
      words_r <= words_nxt;
      dq_r <= dq_nxt;
      oe_n_r <= oe_n_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign array_addr_o = addr_r;
  assign dq_o = dq_r;
  assign dq_oe_n_o = oe_n_r;
  assign rdy_o = rdy_r;
  assign sync_mode_o = sync_en_r;

endmodule // fbrs_seq
`default_nettype wire

// >>> hdl/fbrs_consts.vh
// constants for the flash burst read sequencer
`ifndef FBRS_CONSTS_VH
`define FBRS_CONSTS_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define FBRS_ADDR_W 24
`define FBRS_DATA_W 16
`define FBRS_WS_W 4
`define FBRS_CNT_W 6

// ----------------------------------------------------------------
// burst modes
// ----------------------------------------------------------------
`define FBRS_MODE_CONT 2'h0
`define FBRS_MODE_W8 2'h1
`define FBRS_MODE_W16 2'h2
`define FBRS_MODE_W32 2'h3

// ----------------------------------------------------------------
// group sizes and line geometry
// ----------------------------------------------------------------
`define FBRS_GRP8 6'h08
`define FBRS_GRP16 6'h10
`define FBRS_GRP32 6'h20
`define FBRS_LINE_LSB 7
`define FBRS_LINE_MASK 7'h7F
`define FBRS_OFS_LSB 0
`define FBRS_OFS_MSB 2
`define FBRS_PEN_BASE 5'h09

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FBRS_RST_DQ 16'h0000
`define FBRS_RST_WS 4'h2
`define FBRS_RST_MODE 2'h0
`define FBRS_RST_ADDR 24'h000000

`endif

// >>> hdl/fbrs_addr_step.v
// next burst address and 128-word line crossing detect
`default_nettype none
`include "fbrs_consts.vh"

module fbrs_addr_step (
  // current address and mode
  input wire [`FBRS_ADDR_W-1:0] addr_i,
  input wire [1:0] mode_i,
  // stepped address
  output reg [`FBRS_ADDR_W-1:0] next_o,
  output wire line_cross_o
);

  reg [`FBRS_ADDR_W-1:0] inc;
  reg [`FBRS_ADDR_W-1:0] msk;

  always @* begin
    // full-width increment rolls over to zero at the top
    inc = addr_i + 24'h000001;
    case (mode_i)
      `FBRS_MODE_W8: msk = 24'h000007;
      `FBRS_MODE_W16: msk = 24'h00000F;
      `FBRS_MODE_W32: msk = 24'h00001F;
      default: msk = 24'h000000;
    endcase
    if (mode_i == `FBRS_MODE_CONT) begin
      next_o = inc;
    end else begin
      next_o = (addr_i & ~msk) | (inc & msk);
    end
  end

  // only a continuous burst leaves its line; wrap groups never do
  assign line_cross_o = (mode_i == `FBRS_MODE_CONT) &&
                        (addr_i[`FBRS_LINE_LSB-1:0] == `FBRS_LINE_MASK);

endmodule // fbrs_addr_step
`default_nettype wire

// >>> verif/fbrs_checker.sv
// assertion checker for the burst read sequencer
`default_nettype none
module fbrs_checker (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // host pins
  input wire logic hw_reset_n_i,
  input wire logic chip_sel_n_i,
  input wire logic address_valid_strobe_n_i,
  input wire logic burst_clk_i,
  input wire logic cfg_wr_i,
  // outputs
  input wire logic [23:0] array_addr_o,
  input wire logic dq_oe_n_o,
  input wire logic rdy_o,
  input wire logic sync_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // properties
  // ----------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_cs_off;
    chip_sel_n_i [*4] |-> dq_oe_n_o && !rdy_o;
  endproperty
  a_cs_off: assert property (p_cs_off) else $error("driven while deselected");
  property p_cs_hold;
    disable iff (rst_i || !hw_reset_n_i) chip_sel_n_i [*4] |=> $stable(array_addr_o);
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("address moved while deselected");
  property p_hw;
    !hw_reset_n_i [*4] |-> !sync_mode_o && dq_oe_n_o;
  endproperty
  a_hw: assert property (p_hw) else $error("hardware reset ignored");
  property p_async;
    !sync_mode_o |-> dq_oe_n_o && !rdy_o;
  endproperty
  a_async: assert property (p_async) else $error("burst output before config");
  property p_cfg;
    cfg_wr_i && hw_reset_n_i |-> ##[1:2] sync_mode_o;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config not taken");
  // the address moves only a few cycles after a burst clock rise
  property p_step;
    $changed(array_addr_o) && sync_mode_o && !chip_sel_n_i |-> $past(burst_clk_i, 2) && $past(burst_clk_i, 3);
  endproperty
  a_step: assert property (p_step) else $error("address moved without clock");
  property p_inc;
    $changed(array_addr_o) && rdy_o && $past(rdy_o) && $past(address_valid_strobe_n_i, 3)
      |-> array_addr_o[2:0] == $past(array_addr_o[2:0]) + 3'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("address step not one");
  property p_rdy_oe;
    rdy_o |-> !dq_oe_n_o;
  endproperty
  a_rdy_oe: assert property (p_rdy_oe) else $error("ready without data");
  c_wait: cover property ($fell(rdy_o) && !dq_oe_n_o);
  c_abort: cover property (!address_valid_strobe_n_i && rdy_o);
  c_top: cover property (rdy_o && array_addr_o == 24'h000000);
endmodule // fbrs_checker
bind fbrs_seq fbrs_checker u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .hw_reset_n_i(hw_reset_n_i),
  .chip_sel_n_i(chip_sel_n_i), .address_valid_strobe_n_i(address_valid_strobe_n_i),
  .burst_clk_i(burst_clk_i), .cfg_wr_i(cfg_wr_i), .array_addr_o(array_addr_o),
  .dq_oe_n_o(dq_oe_n_o), .rdy_o(rdy_o), .sync_mode_o(sync_mode_o));
`default_nettype wire

// >>> verif/fbrs_host.sv
// host controller model driving the burst pins
`default_nettype none
module fbrs_host (
  // bench control
  input wire logic mclk_i,
  input wire logic en_i,
  input wire logic req_i,
  input wire logic [23:0] addr_i,
  // device pins
  output logic chip_sel_n_o,
  output logic address_valid_strobe_n_o,
  output logic burst_clk_o,
  output logic [23:0] addr_o,
  output logic smp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph_r = 3'h0;
  logic pend_r = 1'b0;
  // clock stands low between bursts, 4 mclk per phase
  assign burst_clk_o = ph_r[2];
  assign smp_o = en_i && ph_r == 3'h3;
  initial begin
    chip_sel_n_o = 1'b1;
    address_valid_strobe_n_o = 1'b1;
    addr_o = 24'h000000;
  end
  always @(posedge mclk_i) begin
    pend_r <= (req_i || pend_r) && !(en_i && ph_r == 3'h0);
    chip_sel_n_o <= !en_i;
    // a dropped enable lets the current period finish, so no runt pulse reaches the pin
    ph_r <= (en_i || ph_r != 3'h0) ? ph_r + 3'h1 : 3'h0;
    if (en_i && ph_r == 3'h0 && (req_i || pend_r)) begin
      address_valid_strobe_n_o <= 1'b0;
      addr_o <= addr_i;
    end else if (ph_r == 3'h7 || !en_i) begin
      // released lines keep no stale address
      address_valid_strobe_n_o <= 1'b1;
      addr_o <= ~addr_o;
    end
  end
endmodule // fbrs_host
`default_nettype wire

// >>> verif/flash_burst_read_sequencer_test.sv
// self-checking testbench of the burst read sequencer
`default_nettype none
module flash_burst_read_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst = 1'b1, hw_n = 1'b1, en = 1'b0, req = 1'b0, cfg_wr = 1'b0, busy = 1'b0, sus = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [3:0] ws = 4'h2;
  logic [23:0] raddr = 24'h000000;
  wire cs_n, avd_n, bclk, smp, oe_n, rdy, sync;
  wire [23:0] haddr, aaddr;
  wire [15:0] dq;
  int n_fail = 0, tests_run = 0, cyc = 0;
  always #2 mclk = ~mclk;
  fbrs_host host (.mclk_i(mclk), .en_i(en), .req_i(req), .addr_i(raddr), .chip_sel_n_o(cs_n),
    .address_valid_strobe_n_o(avd_n), .burst_clk_o(bclk), .addr_o(haddr), .smp_o(smp));
  fbrs_seq dut (.mclk_i(mclk), .rst_i(rst), .hw_reset_n_i(hw_n), .chip_sel_n_i(cs_n),
    .address_valid_strobe_n_i(avd_n), .burst_clk_i(bclk), .addr_i(haddr), .cfg_wr_i(cfg_wr),
    .cfg_mode_i(mode), .cfg_wait_i(ws), .array_data_i(aaddr[15:0] ^ {2{aaddr[23:16]}}),
    .bank_busy_i(busy), .sect_suspended_i(sus), .status_data_i(16'hC35A), .array_addr_o(aaddr),
    .dq_o(dq), .dq_oe_n_o(oe_n), .rdy_o(rdy), .sync_mode_o(sync));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      test_done;
    end
  end
  // -------------------------------------
  // one burst, expectation rebuilt per rise
  // -------------------------------------
  task automatic burst(input logic [23:0] a, input logic [1:0] m, input logic [3:0] w, input bit stop);
    logic [23:0] cur, msk;
    int pen, pw, nw, k;
    @(posedge mclk);
    cur = a;
    msk = m == 2'h0 ? 24'hFFFFFF : (24'h000004 << m) - 24'h000001;
    pen = (m == 2'h0 && !sus && a[2:0] + w > 9) ? a[2:0] + w - 9 : 0;
    pw = 0;
    nw = 0;
    cfg_wr <= 1'b1;
    mode <= m;
    ws <= w;
    raddr <= a;
    req <= 1'b1;
    en <= 1'b1;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    req <= 1'b0;
    for (k = 0; k <= w + 14 + (4 << m); k++) begin
      do @(posedge mclk); while (smp !== 1'b1);
      if (k == w) check(rdy, 1'b0);
      else if (k > w && pw > 0) begin
        check(rdy, 1'b0);
        pw--;
      end else if (k > w && m != 2'h0 && nw == (4 << m)) check(oe_n, 1'b1);
      else if (k > w) begin
        check({rdy, dq}, {1'b1, cur[15:0] ^ {2{cur[23:16]}}});
        if (m == 2'h0 && cur[6:0] == 7'h7F) pw = pen;
        cur = (cur & ~msk) | ((cur + 24'h000001) & msk);
        nw++;
      end
    end
    if (stop) begin
      en <= 1'b0;
      repeat (6) @(posedge mclk);
      check({oe_n, rdy}, 2'h2);
    end
  endtask
  task automatic t_boundary;
    burst(24'h00007C, 2'h0, 4'h6, 1'b1);
    burst(24'h00017F, 2'h0, 4'h5, 1'b1);
    burst(24'h00027E, 2'h0, 4'h4, 1'b1);
    burst(24'h00037D, 2'h0, 4'h4, 1'b1);
    burst(24'h00047F, 2'h0, 4'h3, 1'b1);
    burst(24'h00057E, 2'h0, 4'h3, 1'b1);
    burst(24'h00067F, 2'h0, 4'h2, 1'b1);
    $display("boundary test done");
  endtask
  task automatic t_wrap;
    burst(24'h00007F, 2'h1, 4'h3, 1'b0);
    burst(24'h00007A, 2'h2, 4'h6, 1'b0);
    burst(24'h0000FD, 2'h3, 4'h2, 1'b1);
    $display("wrap test done");
  endtask
  task automatic t_busy;
    burst(24'hFFFFFE, 2'h0, 4'h4, 1'b0);
    busy <= 1'b1;
    repeat (2) do @(posedge mclk); while (smp !== 1'b1);
    check(dq, 16'hC35A);
    busy <= 1'b0;
    burst(24'h000123, 2'h0, 4'h2, 1'b0);
    sus <= 1'b1;
    burst(24'h00017F, 2'h0, 4'h6, 1'b1);
    sus <= 1'b0;
    $display("abort and busy test done");
  endtask
  task automatic t_reset;
    hw_n <= 1'b0;
    repeat (6) @(posedge mclk);
    check({sync, oe_n}, 2'h1);
    hw_n <= 1'b1;
    repeat (3) @(posedge mclk);
    burst(24'h00000A, 2'h0, 4'h2, 1'b1);
    $display("hardware reset test done");
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check({sync, oe_n, rdy}, 3'h2);
    t_boundary;
    t_wrap;
    t_busy;
    t_reset;
    test_done;
  end
endmodule // flash_burst_read_sequencer_test
`default_nettype wire
